// ---- rtc_irq_pkg.sv ----
// Purpose: shared constants and types for the rtc interrupt router
// Assumes: 10 MHz system clock, 32.768 kHz timebase tick arriving as a pin
// Notes: register offsets are byte addresses on the device register port
package rtc_irq_pkg;

  localparam logic [7:0] ROUTE_A_CTRL_ADDR = 8'h29;
  localparam logic [7:0] ROUTE_B_CTRL_ADDR = 8'h2A;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // enable register bit positions
  localparam int BIT_LEVEL = 7;
  localparam int BIT_PERIODIC = 6;
  localparam int BIT_CORRECTION = 5;
  localparam int BIT_ALARM_ONE = 4;
  localparam int BIT_ALARM_TWO = 3;
  localparam int BIT_STAMP = 2;
  localparam int BIT_BATTERY = 1;
  localparam int BIT_WATCHDOG = 0;
  localparam int NUM_SOURCES = 7;

  // pin mode encodings that select interrupt output
  localparam logic [1:0] PIN_MODE_IRQ_A = 2'h2;
  localparam logic [1:0] PIN_FUNC_IRQ_B = 2'h2;

  // fast correction schedule
  localparam logic [2:0] MINUTE_PERIOD_LAST = 3'h7;
  localparam logic [5:0] SECOND_LAST = 6'h3B;
  localparam logic [7:0] COUNT_ZERO = 8'h00;

  // 128 Hz release clock from 32.768 kHz timebase: 256 ticks
  localparam logic [7:0] TICKS_PER_128HZ_LAST = 8'hFF;

  typedef struct packed {
    logic periodic;
    logic correction;
    logic alarm_one;
    logic alarm_two;
    logic stamp;
    logic battery;
    logic watchdog;
  } source_t;

  typedef struct packed {
    logic level_pulse_sel;
    source_t en;
  } route_ctrl_t;

  typedef enum logic {sched_idle, sched_run} sched_state_t;

endpackage

// ---- rtc_irq_router.sv ----
// Purpose: route rtc interrupt sources to two active-low outputs, plus the fast offset pulse scheduler
// Assumes: event and flag inputs come from same-clock logic; tick_32k is an external pin
// Notes: outputs are registered; irq_out_a is open drain, irq_out_b push-pull on the stamp pin
`timescale 1ns/10ps
module rtc_irq_router
  import rtc_irq_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // register port
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // timebase and calendar
  input wire logic tick_32k,
  input wire logic second_tick,
  input wire logic [5:0] current_second,
  input wire logic minute_tick,
  input wire logic [7:0] offset_value,
  input wire logic offset_fast_select,
  // source events and flags
  input wire source_t src_event,
  input wire source_t src_flag,
  // pin configuration
  input wire logic [1:0] irq_a_pin_mode,
  input wire logic [1:0] stamp_pin_function,
  // timebase correction
  output logic correction_pulse,
  output logic correction_add,
  // pins
  output logic irq_out_a,
  output logic irq_out_a_oe,
  output logic stamp_pin,
  output logic stamp_pin_oe,
  output logic all_flag_monitor
);

  // register and scheduler state
  route_ctrl_t route_ctrl [2];
  route_ctrl_t next_route_ctrl [2];
  logic [7:0] next_reg_rdata;
  sched_state_t state;
  sched_state_t next_state;
  logic [2:0] minute_count;
  logic [2:0] next_minute_count;
  logic [7:0] remaining;
  logic [7:0] next_remaining;
  logic sched_add;
  logic next_sched_add;
  logic next_correction_pulse;
  logic next_correction_add;
  // 128 Hz release clock from the synchronised timebase
  logic tick_meta;
  logic tick_sync;
  logic tick_prev;
  logic [7:0] tick_count;
  logic [7:0] next_tick_count;
  logic release_128;
  logic next_release_128;
  // shaped outputs
  logic [1:0] pulse_hold;
  logic [1:0] next_pulse_hold;
  logic [1:0] pulse_armed, next_pulse_armed;
  logic [1:0] active;
  logic next_irq_out_a;
  logic next_irq_out_a_oe;
  logic next_stamp_pin;
  logic next_stamp_pin_oe;
  logic next_all_flag_monitor;
  source_t trig;
  logic [7:0] mag;

  always_comb begin
    next_route_ctrl[0] = route_ctrl[0];
    next_route_ctrl[1] = route_ctrl[1];
    if (reg_wr && reg_addr == ROUTE_A_CTRL_ADDR) begin
      next_route_ctrl[0] = route_ctrl_t'(reg_wdata);
    end
    if (reg_wr && reg_addr == ROUTE_B_CTRL_ADDR) begin
      next_route_ctrl[1] = route_ctrl_t'(reg_wdata);
    end
    // unmapped addresses read zero
    next_reg_rdata = 8'h00;
    if (reg_addr == ROUTE_A_CTRL_ADDR) begin
      next_reg_rdata = route_ctrl[0];
    end else if (reg_addr == ROUTE_B_CTRL_ADDR) begin
      next_reg_rdata = route_ctrl[1];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      route_ctrl[0] <= CTRL_RESET;
      route_ctrl[1] <= CTRL_RESET;
      reg_rdata <= 8'h00;
    end else begin
      route_ctrl[0] <= next_route_ctrl[0];
      route_ctrl[1] <= next_route_ctrl[1];
      reg_rdata <= next_reg_rdata;
    end
  end

  // magnitude of the signed offset; -128 gives 128
  always_comb begin
    mag = offset_value[7] ? 8'((~offset_value) + 8'h01) : offset_value;
  end

  // fast correction scheduler
  always_comb begin
    next_state = state;
    next_minute_count = minute_count;
    next_remaining = remaining;
    next_sched_add = sched_add;
    next_correction_pulse = 1'b0;
    next_correction_add = correction_add;
    if (minute_tick) begin
      next_minute_count = 3'((minute_count == MINUTE_PERIOD_LAST) ? 3'h0 : minute_count + 3'h1);
    end
    unique case (state)
      sched_idle: begin
        // start every eighth minute at second 00; the first pulse lands on second 00 itself
        if (offset_fast_select && second_tick && current_second == 6'h00 &&
            minute_count == 3'h0 && mag != COUNT_ZERO) begin
          next_state = (mag == 8'h01) ? sched_idle : sched_run;
          next_remaining = 8'(mag - 8'h01);
          next_sched_add = ~offset_value[7];
          next_correction_pulse = 1'b1;
          next_correction_add = ~offset_value[7];
        end
      end
      sched_run: begin
        // one pulse per second, spilling into following minutes
        if (!offset_fast_select) begin
          next_state = sched_idle;
        end else if (second_tick) begin
          // pulse tells the timebase to add or drop one count
          next_correction_pulse = 1'b1;
          next_correction_add = sched_add;
          next_remaining = 8'(remaining - 8'h01);
          if (remaining == 8'h01) begin
            next_state = sched_idle;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= sched_idle;
      minute_count <= 3'h0;
      remaining <= COUNT_ZERO;
      sched_add <= 1'b0;
      correction_pulse <= 1'b0;
      correction_add <= 1'b0;
    end else begin
      state <= next_state;
      minute_count <= next_minute_count;
      remaining <= next_remaining;
      sched_add <= next_sched_add;
      correction_pulse <= next_correction_pulse;
      correction_add <= next_correction_add;
    end
  end

  // release clock: a 128 Hz strobe, unrelated in phase to the events
  always_comb begin
    next_tick_count = tick_count;
    next_release_128 = 1'b0;
    if (tick_sync && !tick_prev) begin
      next_tick_count = 8'(tick_count + 8'h01);
      next_release_128 = (tick_count == TICKS_PER_128HZ_LAST);
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tick_meta <= 1'b0;
      tick_sync <= 1'b0;
      tick_prev <= 1'b0;
      tick_count <= 8'h00;
      release_128 <= 1'b0;
    end else begin
      tick_meta <= tick_32k;
      tick_sync <= tick_meta;
      tick_prev <= tick_sync;
      tick_count <= next_tick_count;
      release_128 <= next_release_128;
    end
  end

  // correction trigger is the scheduler's own pulse; the rest arrive as events
  always_comb begin
    trig = src_event;
    trig.correction = next_correction_pulse;
  end

  // per-output shaping, identical for both routes
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_route
      logic pulse_trig;
      logic level_on;
      logic flag_cleared;
      // enabled triggers ORed, correction included; stamp fires regardless of its flag
      assign pulse_trig = |(trig & route_ctrl[i].en);
      // level follows enabled flags; correction has no flag, stays pulse-only
      assign level_on = |(src_flag & route_ctrl[i].en & ~source_t'(7'h20));
      // the pulse ends once no enabled flag is high, but never while correction is enabled
      assign flag_cleared = ~|(src_flag & route_ctrl[i].en & ~source_t'(7'h20)) &&
                            !route_ctrl[i].en.correction;
      always_comb begin
        next_pulse_hold[i] = pulse_hold[i];
        next_pulse_armed[i] = pulse_armed[i];
        // first 128 Hz strobe arms, the second releases, so a pulse not ended early by flag_cleared lasts one to two periods
        if (release_128) begin
          next_pulse_hold[i] = pulse_hold[i] && !pulse_armed[i];
          next_pulse_armed[i] = pulse_hold[i] && !pulse_armed[i];
        end
        if (pulse_hold[i] && flag_cleared) begin
          next_pulse_hold[i] = 1'b0;
        end
        // a fresh trigger wins over release and restarts the period count
        if (pulse_trig) begin
          next_pulse_hold[i] = 1'b1;
          next_pulse_armed[i] = 1'b0;
        end
        active[i] = next_pulse_hold[i] || (route_ctrl[i].level_pulse_sel && level_on);
      end
    end
  endgenerate

  // pin drivers and monitor
  always_comb begin
    // open drain: drive low only while active and pin mode selects it
    next_irq_out_a = 1'b0;
    next_irq_out_a_oe = active[0] && irq_a_pin_mode == PIN_MODE_IRQ_A;
    // push-pull active low on the stamp pin
    next_stamp_pin_oe = stamp_pin_function == PIN_FUNC_IRQ_B;
    next_stamp_pin = ~(active[1] && next_stamp_pin_oe);
    next_all_flag_monitor = |src_flag;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      {pulse_armed, pulse_hold} <= 4'h0;
      irq_out_a <= 1'b0;
      irq_out_a_oe <= 1'b0;
      stamp_pin <= 1'b1;
      stamp_pin_oe <= 1'b0;
      all_flag_monitor <= 1'b0;
    end else begin
      {pulse_armed, pulse_hold} <= {next_pulse_armed, next_pulse_hold};
      irq_out_a <= next_irq_out_a;
      irq_out_a_oe <= next_irq_out_a_oe;
      stamp_pin <= next_stamp_pin;
      stamp_pin_oe <= next_stamp_pin_oe;
      all_flag_monitor <= next_all_flag_monitor;
    end
  end

endmodule

// ---- rtc_irq_router_asserts.sv ----
// Purpose: port checks for the rtc interrupt router
// Assumes: route registers change only through the register port
// Notes: shadow copies of both route registers supply the enables
`timescale 1ns/10ps
module rtc_irq_router_asserts
  import rtc_irq_pkg::*;
(
  // clock, reset and register port
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  // sources and pin setup
  input wire logic second_tick,
  input wire source_t src_event,
  input wire source_t src_flag,
  input wire logic [1:0] irq_a_pin_mode,
  input wire logic [1:0] stamp_pin_function,
  // outputs
  input wire logic correction_pulse,
  input wire logic irq_out_a,
  input wire logic irq_out_a_oe,
  input wire logic stamp_pin,
  input wire logic stamp_pin_oe,
  input wire logic all_flag_monitor
);
  logic [7:0] ra, rb, next_ra, next_rb;
  logic a_on, b_on;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // shadow the route registers, mapped writes only
  always_comb begin
    next_ra = (reg_wr && reg_addr == ROUTE_A_CTRL_ADDR) ? reg_wdata : ra;
    next_rb = (reg_wr && reg_addr == ROUTE_B_CTRL_ADDR) ? reg_wdata : rb;
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ra <= CTRL_RESET;
      rb <= CTRL_RESET;
    end else begin
      ra <= next_ra;
      rb <= next_rb;
    end
  end
  // pin setup decoded once
  assign a_on = irq_a_pin_mode == PIN_MODE_IRQ_A;
  assign b_on = stamp_pin_function == PIN_FUNC_IRQ_B;
  // correction has no flag, so it is masked out of the level terms
  sequence s_a_trig; !ra[7] && a_on && |(src_event & ra[6:0] & 7'h5F); endsequence
  sequence s_a_level; ra[7] && a_on && |(src_flag & ra[6:0] & 7'h5F); endsequence
  sequence s_b_level; rb[7] && b_on && |(src_flag & rb[6:0] & 7'h5F); endsequence
  property p_open_drain; irq_out_a == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain) else $error("line a data not low");
  property p_mode_gate; !$past(a_on) |-> !irq_out_a_oe; endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("line a driven while off");
  property p_b_enable; !$past(reset) |-> stamp_pin_oe == $past(b_on); endproperty
  a_b_enable: assert property (p_b_enable) else $error("stamp pin enable wrong");
  property p_monitor; all_flag_monitor == |$past(src_flag); endproperty
  a_monitor: assert property (p_monitor) else $error("monitor mismatch");
  property p_corr_sec; correction_pulse |-> $past(second_tick); endproperty
  a_corr_sec: assert property (p_corr_sec) else $error("correction off second");
  property p_pulse; s_a_trig |-> ##2 irq_out_a_oe; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse not raised");
  property p_level; s_a_level [*3] |-> irq_out_a_oe; endproperty
  a_level: assert property (p_level) else $error("level a not held");
  property p_level_b; s_b_level [*3] |-> !stamp_pin; endproperty
  a_level_b: assert property (p_level_b) else $error("level b not held");
endmodule

// ---- rtc_host_irq_model.sv ----
// Purpose: host interrupt input facing both interrupt pins
// Assumes: line a has a pull-up, line b has none
// Notes: counts each new request seen on line a
`timescale 1ns/10ps
module rtc_host_irq_model (
  // pins from the device
  input wire logic clk_sys,
  input wire logic irq_out_a,
  input wire logic irq_out_a_oe,
  input wire logic stamp_pin,
  input wire logic stamp_pin_oe,
  // levels the host sees
  output logic irq_a_n,
  output logic irq_b_n,
  output int falls_a
);
  logic wander = 1'b0;
  // undriven b line changes every cycle so a stale value never passes
  always @(posedge clk_sys) wander <= ~wander;
  assign irq_a_n = irq_out_a_oe ? irq_out_a : 1'b1;
  assign irq_b_n = stamp_pin_oe ? stamp_pin : wander;
  // request count on line a
  initial falls_a = 0;
  always @(negedge irq_a_n) falls_a = falls_a + 1;
endmodule

// ---- rtc_irq_router_tb_top.sv ----
// Purpose: self-checking bench for the rtc interrupt router
// Assumes: timebase pin sped up, one release period is 1024 cycles
// Notes: host model resolves the pins
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module rtc_irq_router_tb_top
  import rtc_irq_pkg::*;
;
  logic clk_sys = 0, reset = 1, reg_wr = 0, tick_32k = 0, second_tick = 0, minute_tick = 0, offset_fast_select = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, offset_value = 8'h00, reg_rdata;
  logic [5:0] current_second = 6'h00;
  logic [1:0] irq_a_pin_mode = 2'h0, stamp_pin_function = 2'h2;
  source_t src_event = '0, src_flag = '0;
  logic correction_pulse, correction_add, irq_out_a, irq_out_a_oe, stamp_pin, stamp_pin_oe, all_flag_monitor;
  logic irq_a_n, irq_b_n;
  logic [6:0] codes [6] = '{7'h40, 7'h10, 7'h08, 7'h04, 7'h02, 7'h01};
  // level-mode flag patterns, applied in order
  logic [6:0] levels [6] = '{7'h01, 7'h41, 7'h43, 7'h03, 7'h01, 7'h00};
  int num_errors = 0, checks = 0, cyc = 0, n_add = 0, n_sub = 0, falls_a, t;
  rtc_irq_router rtc_irq_router_inst (.clk_sys, .reset, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .tick_32k,
    .second_tick, .current_second, .minute_tick, .offset_value, .offset_fast_select, .src_event, .src_flag,
    .irq_a_pin_mode, .stamp_pin_function, .correction_pulse, .correction_add, .irq_out_a, .irq_out_a_oe,
    .stamp_pin, .stamp_pin_oe, .all_flag_monitor);
  rtc_host_irq_model rtc_host_irq_model_inst (.clk_sys, .irq_out_a, .irq_out_a_oe, .stamp_pin, .stamp_pin_oe,
    .irq_a_n, .irq_b_n, .falls_a);
  // clock
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  // timebase, correction tally and hang limit
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc % 2 == 1) tick_32k <= ~tick_32k;
    if (correction_pulse === 1'b1) begin
      if (correction_add) n_add++;
      else n_sub++;
    end
    if (cyc == 30000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step(1);
    reg_wr = 1'b0;
    // let one edge pass so back-to-back writes never re-raise the strobe in the same step
    step(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    step(2);
    `CHK("reg_rdata", e, reg_rdata)
  endtask
  // raise a flag with its trigger, then let the pin settle
  task automatic fire(input logic [6:0] f);
    src_flag = src_flag | f;
    src_event = f;
    step(1);
    src_event = '0;
    step(3);
  endtask
  // seconds at three cycles each; minute tick after second 59
  task automatic minutes(input int n);
    for (int m = 0; m < n; m++) begin
      for (int s = 0; s < 60; s++) begin
        current_second = 6'(s);
        second_tick = 1'b1;
        step(1);
        second_tick = 1'b0;
        step(2);
      end
      minute_tick = 1'b1;
      step(1);
      minute_tick = 1'b0;
    end
  endtask
  initial begin
    step(10);
    reset = 1'b0;
    step(1);
    rd(ROUTE_A_CTRL_ADDR, CTRL_RESET);
    rd(ROUTE_B_CTRL_ADDR, CTRL_RESET);
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h00);
    wr(ROUTE_A_CTRL_ADDR, 8'h5F);
    wr(ROUTE_B_CTRL_ADDR, 8'h10);
    rd(ROUTE_A_CTRL_ADDR, 8'h5F);
    // pin mode off blocks line a
    fire(7'h08);
    `CHK("irq_a_off", 1'b1, irq_a_n)
    src_flag = '0;
    step(4);
    irq_a_pin_mode = PIN_MODE_IRQ_A;
    foreach (codes[i]) begin
      fire(codes[i]);
      `CHK("irq_a_pulse", 1'b0, irq_a_n)
      `CHK("irq_b_pulse", codes[i] != 7'h10, irq_b_n)
      src_flag = '0;
      step(4);
      `CHK("irq_a_clear", 1'b1, irq_a_n)
    end
    // release by slow clock, repeat stamp
    wr(ROUTE_A_CTRL_ADDR, 8'h04);
    fire(7'h04);
    t = 0;
    while (irq_a_n !== 1'b1 && t < 3000) begin
      step(1);
      t++;
    end
    `CHK("release_time", 1'b1, t >= 1000 && t <= 2100)
    fire(7'h04);
    `CHK("stamp_again", 1'b0, irq_a_n)
    src_flag = '0;
    wr(ROUTE_A_CTRL_ADDR, 8'hC2);
    wr(ROUTE_B_CTRL_ADDR, 8'hC2);
    foreach (codes[i]) begin
      src_flag = levels[i];
      step(4);
      `CHK("irq_a_level", i == 0 || i == 4 || i == 5, irq_a_n)
      `CHK("monitor", i != 5, all_flag_monitor)
    end
    `CHK("irq_b_level", 1'b1, irq_b_n)
    wr(ROUTE_A_CTRL_ADDR, 8'hA0);
    offset_fast_select = 1'b1;
    offset_value = 8'h03;
    t = falls_a;
    minutes(8);
    `CHK("add_count", 3, n_add)
    `CHK("corr_irq", 1'b1, falls_a > t)
    offset_value = 8'h80;
    minutes(8);
    `CHK("remove_count", 128, n_sub)
    offset_fast_select = 1'b0;
    complete_run();
  end
endmodule
bind rtc_irq_router rtc_irq_router_asserts rtc_irq_router_asserts_inst (.clk_sys, .reset, .reg_wr, .reg_addr,
  .reg_wdata, .second_tick, .src_event, .src_flag, .irq_a_pin_mode, .stamp_pin_function, .correction_pulse,
  .irq_out_a, .irq_out_a_oe, .stamp_pin, .stamp_pin_oe, .all_flag_monitor);
